//--- design/crf_top.sv
// Purpose: receive acceptance filtering, receive buffers and related registers
// Assumes: frame engine on the same clock; FRAME_DONE pulses once per frame
// Notes:   foreground holds until software clears the full flag
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module crf_top import crf_pkg::*; #(
	parameter int ADDR_W = 12
) (
	input  wire logic              CLOCK,
	input  wire logic              RSTN,
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	input  wire logic              WVALID,
	output logic                   WREADY,
	output logic [1:0]             BRESP,
	output logic                   BVALID,
	input  wire logic              BREADY,
	input  wire logic [ADDR_W-1:0] ARADDR,
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	output logic [31:0]            RDATA,
	output logic [1:0]             RRESP,
	output logic                   RVALID,
	input  wire logic              RREADY,
	input  wire logic              FRAME_DONE,
	input  wire crf_frame_t        FRAME_IN,
	input  wire logic              TRANSMITTING,
	input  wire logic              ARB_LOST,
	input  wire logic [2:0]        TX_BUF_AVAIL,
	input  wire logic [7:0]        TX_ERR_CNT,
	output logic                   ACK_ENABLE,
	output logic                   RX_FULL,
	output logic                   TX_EMPTY_IRQ,
	output logic                   SOFT_RESET,
	output logic                   LOOPBACK
);

	function automatic logic byte_ok(input logic [7:0] idb, input logic [7:0] c,
			input logic [7:0] m);
		// a set mask bit makes that bit a don't-care
		return &((~(idb ^ c)) | m);
	endfunction

	function automatic logic [2:0] lowest(input logic [7:0] h);
		logic [2:0] r;
		r = '0;
		for (int i = 7; i >= 0; i--) begin
			if (h[i])
				r = 3'(i);
		end
		return r;
	endfunction

	function automatic logic is_mapped(input logic [9:0] x);
		return x == IDX_CTRL || x == IDX_STAT || x == IDX_TCTRL || x == IDX_MODEHIT
			|| x == IDX_TXERR || (x >= IDX_CODE && x <= IDX_BG + 10'h003)
			|| x == IDX_BGIDE;
	endfunction

	logic [7:0]       code_r [8];
	logic [7:0]       mask_r [8];
	logic [1:0]       mode_r;
	logic [2:0]       hit_r;
	logic             srst_r;
	logic             loop_r;
	logic             full_r;
	logic             ovr_r;
	logic [2:0]       tctrl_r;
	logic [7:0]       txerr_r;
	crf_frame_t       fg_r;
	crf_frame_t       bg_r;
	logic             ack_r;
	logic             irq_r;
	logic             aw_rdy_r;
	logic             w_rdy_r;
	logic [9:0]       aw_idx_r;
	logic [7:0]       wd_r;
	logic             ws_r;
	logic             bvalid_r;
	logic [1:0]       bresp_r;
	logic             ar_rdy_r;
	logic             rvalid_r;
	logic [31:0]      rdata_r;
	logic [1:0]       rresp_r;
	logic [9:0]       rd_idx_r;
	logic [7:0]       idb [4];
	logic [3:0]       pos_m [2];
	logic [3:0]       half_m [2];
	logic [3:0]       head_m [2];
	logic [7:0]       hits;
	logic             own;
	logic             accept;
	logic             clr_full;
	logic             clr_ovr;
	logic             fill;
	logic             wr_go;
	logic             wr_en;
	logic [9:0]       ar_idx;
	logic [7:0]       rd_byte;

	// identifier byte 0 is the most significant byte of the frame id
	for (genvar k = 0; k < 4; k++) begin : g_idb
		assign idb[k] = FRAME_IN.id[31-8*k -: 8];
	end

	for (genvar b = 0; b < 2; b++) begin : g_bank
		for (genvar k = 0; k < 4; k++) begin : g_pair
			assign pos_m[b][k]  = byte_ok(idb[k], code_r[4*b+k], mask_r[4*b+k]);
			assign half_m[b][k] = byte_ok(idb[k%2], code_r[4*b+k], mask_r[4*b+k]);
			assign head_m[b][k] = byte_ok(idb[0], code_r[4*b+k], mask_r[4*b+k]);
		end
	end

	always_comb begin
		hits = '0;
		case (crf_mode_t'(mode_r))
			CRF_TWO: begin
				for (int b = 0; b < 2; b++) begin
					hits[b] = pos_m[b][0] & pos_m[b][1]
						& (~FRAME_IN.ide | (pos_m[b][2] & pos_m[b][3]));
				end
			end
			CRF_FOUR: begin
				for (int b = 0; b < 2; b++) begin
					hits[2*b]   = half_m[b][0] & half_m[b][1];
					hits[2*b+1] = half_m[b][2] & half_m[b][3];
				end
			end
			CRF_EIGHT: begin
				hits = {head_m[1], head_m[0]};
			end
			default: begin
				hits = '0;
			end
		endcase
	end

	// own frame only while still transmitting; lost arbitration makes us a receiver
	assign own      = TRANSMITTING & ~ARB_LOST & ~loop_r;
	assign accept   = FRAME_DONE & (|hits) & ~own & ~srst_r;
	assign clr_full = wr_en && aw_idx_r == IDX_STAT && wd_r[STAT_FULL];
	assign clr_ovr  = wr_en && aw_idx_r == IDX_STAT && wd_r[STAT_OVR];
	// a frame arriving as software clears the flag still loads
	assign fill     = accept & (~full_r | clr_full);

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			bg_r <= '0;
		end else if (FRAME_DONE) begin
			bg_r <= FRAME_IN;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			fg_r  <= '0;
			hit_r <= '0;
		end else if (fill) begin
			fg_r  <= FRAME_IN;
			hit_r <= lowest(hits);
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			full_r <= 1'h0;
			ovr_r  <= 1'h0;
		end else begin
			full_r <= (full_r & ~clr_full) | fill;
			// a refused frame in the clearing cycle still marks the overrun
			ovr_r  <= (ovr_r & ~clr_ovr) | (accept & ~fill);
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			ack_r   <= 1'h0;
			irq_r   <= 1'h0;
			txerr_r <= BYTE_RST;
		end else begin
			ack_r   <= ~own;
			irq_r   <= |(TX_BUF_AVAIL & tctrl_r);
			txerr_r <= TX_ERR_CNT;
		end
	end

	// configuration registers; only the low byte lane carries data
	assign wr_go = ~aw_rdy_r & ~w_rdy_r & ~bvalid_r;
	assign wr_en = wr_go & ws_r;

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			mode_r <= '0;
			srst_r <= 1'h0;
			loop_r <= 1'h0;
			for (int i = 0; i < 8; i++) begin
				code_r[i] <= BYTE_RST;
				mask_r[i] <= BYTE_RST;
			end
		end else if (wr_en) begin
			if (aw_idx_r == IDX_MODEHIT)
				mode_r <= wd_r[MODE_LSB +: 2];
			if (aw_idx_r == IDX_CTRL) begin
				srst_r <= wd_r[CTRL_SRST];
				loop_r <= wd_r[CTRL_LOOP];
			end
			for (int i = 0; i < 8; i++) begin
				if (aw_idx_r == IDX_CODE + 10'(i))
					code_r[i] <= wd_r;
				if (aw_idx_r == IDX_MASK + 10'(i))
					mask_r[i] <= wd_r;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			tctrl_r <= '0;
		end else if (srst_r) begin
			tctrl_r <= '0;
		end else if (wr_en && aw_idx_r == IDX_TCTRL) begin
			tctrl_r <= wd_r[TCTRL_W-1:0];
		end
	end

	// write channel: address and data taken in either order, one write in flight
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			aw_rdy_r <= 1'h1;
			w_rdy_r  <= 1'h1;
			aw_idx_r <= '0;
			wd_r     <= BYTE_RST;
			ws_r     <= 1'h0;
			bvalid_r <= 1'h0;
			bresp_r  <= RESP_OKAY;
		end else begin
			if (AWVALID && aw_rdy_r) begin
				aw_idx_r <= AWADDR[11:2];
				aw_rdy_r <= 1'h0;
			end
			if (WVALID && w_rdy_r) begin
				wd_r    <= WDATA[7:0];
				ws_r    <= WSTRB[0];
				w_rdy_r <= 1'h0;
			end
			if (wr_go) begin
				bvalid_r <= 1'h1;
				bresp_r  <= is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_r && BREADY) begin
				bvalid_r <= 1'h0;
				aw_rdy_r <= 1'h1;
				w_rdy_r  <= 1'h1;
			end
		end
	end

	assign ar_idx = ARADDR[11:2];

	always_comb begin
		rd_byte = BYTE_RST;
		case (ar_idx)
			IDX_CTRL:    rd_byte = {6'h00, loop_r, srst_r};
			IDX_STAT:    rd_byte = {6'h00, ovr_r, full_r};
			IDX_TCTRL:   rd_byte = {5'h00, tctrl_r};
			IDX_MODEHIT: rd_byte = {2'h0, mode_r, 1'h0, hit_r};
			IDX_TXERR:   rd_byte = txerr_r;
			IDX_FGIDE:   rd_byte = {7'h00, fg_r.ide};
			IDX_BGIDE:   rd_byte = {7'h00, bg_r.ide};
			default: begin
				for (int i = 0; i < 8; i++) begin
					if (ar_idx == IDX_CODE + 10'(i))
						rd_byte = code_r[i];
					if (ar_idx == IDX_MASK + 10'(i))
						rd_byte = mask_r[i];
				end
				for (int k = 0; k < 4; k++) begin
					if (ar_idx == IDX_FG + 10'(k))
						rd_byte = fg_r.id[31-8*k -: 8];
					if (ar_idx == IDX_BG + 10'(k))
						rd_byte = bg_r.id[31-8*k -: 8];
				end
			end
		endcase
	end

	// read channel: data registered on the same edge that takes the address
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			ar_rdy_r <= 1'h1;
			rvalid_r <= 1'h0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= RESP_OKAY;
			rd_idx_r <= '0;
		end else if (ARVALID && ar_rdy_r) begin
			ar_rdy_r <= 1'h0;
			rvalid_r <= 1'h1;
			rdata_r  <= {24'h00_0000, rd_byte};
			rresp_r  <= is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
			rd_idx_r <= ar_idx;
		end else if (rvalid_r && RREADY) begin
			rvalid_r <= 1'h0;
			ar_rdy_r <= 1'h1;
		end
	end

	assign AWREADY      = aw_rdy_r;
	assign WREADY       = w_rdy_r;
	assign BVALID       = bvalid_r;
	assign BRESP        = bresp_r;
	assign ARREADY      = ar_rdy_r;
	assign RVALID       = rvalid_r;
	assign RDATA        = rdata_r;
	assign RRESP        = rresp_r;
	assign ACK_ENABLE   = ack_r;
	assign RX_FULL      = full_r;
	assign TX_EMPTY_IRQ = irq_r;
	assign SOFT_RESET   = srst_r;
	assign LOOPBACK     = loop_r;

	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);

	a_own_no_fill: assert property (
		FRAME_DONE && TRANSMITTING && !ARB_LOST && !loop_r && !full_r
		|=> !full_r && !ack_r)
		else $error("own frame reached foreground or was acked");

	a_loop_accept: assert property (
		FRAME_DONE && TRANSMITTING && loop_r && (|hits) && !srst_r && !full_r
		|=> full_r && fg_r == $past(FRAME_IN))
		else $error("loop-back frame not accepted");

	a_arb_lost_rx: assert property (
		FRAME_DONE && TRANSMITTING && ARB_LOST && (|hits) && !srst_r && !full_r
		|=> full_r && ack_r && fg_r == $past(FRAME_IN))
		else $error("frame after lost arbitration dropped");

	a_hit_lowest: assert property (
		fill |=> ($past(hits) & ((8'h01 << hit_r) - 8'h01)) == 8'h00
			&& $past(hits) >> hit_r != 8'h00)
		else $error("hit indicator not lowest match");

	a_bank_split: assert property (
		crf_mode_t'(mode_r) == CRF_TWO |-> hits[7:2] == 6'h00)
		else $error("two-filter mode produced high hits");

	a_closed_none: assert property (
		crf_mode_t'(mode_r) == CRF_CLOSED && !full_r |=> !full_r)
		else $error("closed filter set full flag");

	a_reserved_zero: assert property (
		rvalid_r && rd_idx_r == IDX_MODEHIT
		|-> rdata_r[31:6] == 26'h000_0000 && !rdata_r[3])
		else $error("reserved mode-and-hit bits not zero");

	a_bg_capture: assert property (
		FRAME_DONE |=> bg_r == $past(FRAME_IN))
		else $error("background buffer missed a frame");

	a_irq_gated: assert property (
		(TX_BUF_AVAIL & tctrl_r) == 3'h0 |=> !TX_EMPTY_IRQ)
		else $error("transmit-empty interrupt not gated");

	a_tctrl_held: assert property (
		srst_r [*2] |-> tctrl_r == 3'h0)
		else $error("transmit control not held in reset");

	a_txerr_mirror: assert property (
		1'h1 ##1 1'h1 |-> txerr_r == $past(TX_ERR_CNT))
		else $error("transmit error count not mirrored");

endmodule

//--- design/crf_pkg.sv
// Purpose: constants and types for the receive acceptance filter block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   printed offsets are register indices; byte address is index times four
//
// Function
// - own transmitted frame goes to background only; no foreground, flag or ack
// - loop-back mode treats own frames like any other received frame
// - after lost arbitration the frame on the bus is received normally
// - several matching filters report the lowest-numbered one as hit
// - two-filter mode compares full extended id or standard id with flags
// - four-filter mode compares top 16 extended bits or standard id
// - eight-filter mode compares only the first 8 identifier bits
// - bank one yields filters 0 / 0-1 / 0-3, bank two 1 / 2-3 / 4-7
// - closed mode never fills foreground and never sets the full flag
// - mode field 00 two, 01 four, 10 eight filters, 11 closed
// - mode-and-hit register: mode 5:4, hit 2:0 read-only, rest zero, reset zero
// - every frame lands in background; only accepted frames signal the CPU
// - code and mask are applied bit by bit to the identifier bytes
// - in two-filter mode extended frames use all four pairs of a bank, standard only two
// - each transmit-empty enable gates its buffer-available event onto the interrupt
// - transmit control is held in reset while soft reset is set
// - transmit error count register is read-only, mirrors counter, resets zero
package crf_pkg;
	localparam logic [9:0] IDX_CTRL    = 10'h100;
	localparam logic [9:0] IDX_STAT    = 10'h101;
	localparam logic [9:0] IDX_TCTRL   = 10'h106;
	localparam logic [9:0] IDX_MODEHIT = 10'h108;
	localparam logic [9:0] IDX_TXERR   = 10'h10F;
	localparam logic [9:0] IDX_CODE    = 10'h110;
	localparam logic [9:0] IDX_MASK    = 10'h118;
	localparam logic [9:0] IDX_FG      = 10'h120;
	localparam logic [9:0] IDX_FGIDE   = 10'h124;
	localparam logic [9:0] IDX_BG      = 10'h128;
	localparam logic [9:0] IDX_BGIDE   = 10'h12C;
	localparam int CTRL_SRST = 0;
	localparam int CTRL_LOOP = 1;
	localparam int STAT_FULL = 0;
	localparam int STAT_OVR  = 1;
	localparam int MODE_LSB  = 4;
	localparam int TCTRL_W   = 3;
	localparam logic [7:0]  BYTE_RST = 8'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {CRF_TWO, CRF_FOUR, CRF_EIGHT, CRF_CLOSED} crf_mode_t;
	typedef struct packed {
		logic [31:0] id;
		logic        ide;
	} crf_frame_t;
endpackage

//--- tb/crf_node_model.sv
// Purpose: stand-in for the other bus nodes handing finished frames to the filter
// Assumes: one frame per call, done strobe lasts one clock
// Notes:   released frame lines show the inverse pattern so stale data is never trusted
`timescale 1ns/1ps
module crf_node_model import crf_pkg::*; (
	input  wire logic CLOCK,
	output logic      FRAME_DONE,
	output crf_frame_t FRAME_IN,
	output logic      TRANSMITTING,
	output logic      ARB_LOST
);
	initial begin
		FRAME_DONE = 1'b0;
		FRAME_IN = '0;
		TRANSMITTING = 1'b0;
		ARB_LOST = 1'b0;
	end
	// frames arrive whole, so bit timing stays legal inside the far engine
	task automatic send(input crf_frame_t f, input logic own, input logic lost);
		@(posedge CLOCK);
		FRAME_DONE   <= 1'b1;
		FRAME_IN     <= f;
		TRANSMITTING <= own;
		ARB_LOST     <= lost;
		@(posedge CLOCK);
		FRAME_DONE   <= 1'b0;
		FRAME_IN     <= ~f;
		TRANSMITTING <= 1'b0;
		ARB_LOST     <= 1'b0;
	endtask
endmodule

//--- tb/tb.sv
// Purpose: register-level tests of acceptance filtering and receive buffers
// Assumes: byte address is four times the register index
// Notes:   error counter is read only under soft reset
`timescale 1ns/1ps
module tb import crf_pkg::*;;
	logic        CLOCK;
	logic        RSTN = 1'b0;
	logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic [11:0] AWADDR = '0, ARADDR = '0;
	logic [31:0] WDATA = '0;
	logic [3:0]  WSTRB = 4'hF;
	logic [2:0]  TX_BUF_AVAIL = 3'h0;
	logic [7:0]  TX_ERR_CNT = 8'h00;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, FRAME_DONE, TRANSMITTING, ARB_LOST;
	logic        ACK_ENABLE, RX_FULL, TX_EMPTY_IRQ, SOFT_RESET, LOOPBACK;
	logic [31:0] RDATA;
	logic [1:0]  BRESP, RRESP;
	crf_frame_t  FRAME_IN;
	int          failures = 0, n_checks = 0;
	logic [1:0]  bresp_exp = RESP_OKAY;
	logic [7:0]  codes [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h11, 8'h22, 8'h55, 8'h66};

	crf_top crf_top_inst (.CLOCK(CLOCK), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.FRAME_DONE(FRAME_DONE), .FRAME_IN(FRAME_IN), .TRANSMITTING(TRANSMITTING),
		.ARB_LOST(ARB_LOST), .TX_BUF_AVAIL(TX_BUF_AVAIL), .TX_ERR_CNT(TX_ERR_CNT),
		.ACK_ENABLE(ACK_ENABLE), .RX_FULL(RX_FULL), .TX_EMPTY_IRQ(TX_EMPTY_IRQ),
		.SOFT_RESET(SOFT_RESET), .LOOPBACK(LOOPBACK));
	crf_node_model crf_node_model_inst (.CLOCK(CLOCK), .FRAME_DONE(FRAME_DONE),
		.FRAME_IN(FRAME_IN), .TRANSMITTING(TRANSMITTING), .ARB_LOST(ARB_LOST));

	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end

	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// handshakes are judged half a cycle early so releases land right after the taking edge
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic ha, hw, hb;
		int n;
		n = 0;
		hb = 1'b0;
		@(posedge CLOCK);
		AWADDR  <= {idx, 2'b00};
		WDATA   <= {24'h00_0000, d};
		AWVALID <= 1'b1;
		WVALID  <= 1'b1;
		BREADY  <= 1'b1;
		while (!hb && n < 50) begin
			@(negedge CLOCK);
			ha = AWVALID & AWREADY;
			hw = WVALID & WREADY;
			hb = BVALID & BREADY;
			if (hb) chk(BRESP, bresp_exp);
			@(posedge CLOCK);
			if (ha) AWVALID <= 1'b0;
			if (hw) WVALID <= 1'b0;
			if (hb) BREADY <= 1'b0;
			n++;
		end
		if (!hb) failures++;
	endtask

	task automatic rd(input logic [9:0] idx, input logic [31:0] e, input logic [1:0] er);
		logic ha, hr;
		int n;
		n = 0;
		hr = 1'b0;
		@(posedge CLOCK);
		ARADDR  <= {idx, 2'b00};
		ARVALID <= 1'b1;
		RREADY  <= 1'b1;
		while (!hr && n < 50) begin
			@(negedge CLOCK);
			ha = ARVALID & ARREADY;
			hr = RVALID & RREADY;
			if (hr) chk({RRESP, RDATA}, {er, e});
			@(posedge CLOCK);
			if (ha) ARVALID <= 1'b0;
			if (hr) RREADY <= 1'b0;
			n++;
		end
		if (!hr) failures++;
	endtask

	// accepted frames are acknowledged by clearing the full flag so the next one can land
	task automatic frm(input logic [31:0] id, input logic ide, own, lost, full,
		input logic [7:0] mh);
		crf_node_model_inst.send(crf_frame_t'({id, ide}), own, lost);
		@(negedge CLOCK);
		chk(RX_FULL, full);
		if (full) begin
			rd(IDX_MODEHIT, {24'h00_0000, mh}, RESP_OKAY);
			wr(IDX_STAT, 8'h01);
		end
	endtask

	task automatic final_report;
		$display("checks=%0d mismatches=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#50000;
		failures++;
		final_report;
	end

	initial begin
		repeat (12) @(posedge CLOCK);
		RSTN <= 1'b1;
		rd(IDX_MODEHIT, 32'h0000_0000, RESP_OKAY);
		wr(IDX_CTRL, 8'h01);
		chk(SOFT_RESET, 1'b1);
		rd(IDX_TXERR, 32'h0000_0000, RESP_OKAY);
		wr(IDX_CTRL, 8'h00);
		rd(10'h0FF, 32'h0000_0000, RESP_SLVERR);
		bresp_exp = RESP_SLVERR;
		wr(10'h0FF, 8'h5A);
		bresp_exp = RESP_OKAY;
		wr(IDX_MODEHIT, 8'hFF);
		rd(IDX_MODEHIT, 32'h0000_0030, RESP_OKAY);
		frm(32'h1122_3344, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		rd(IDX_BG + 10'h003, 32'h0000_0044, RESP_OKAY);
		rd(IDX_BGIDE, 32'h0000_0001, RESP_OKAY);
		$display("test closed done");
		for (int i = 0; i < 8; i++) wr(IDX_CODE + 10'(i), codes[i]);
		wr(IDX_MODEHIT, 8'h00);
		frm(32'h1122_3344, 1'b1, 1'b0, 1'b0, 1'b1, 8'h00);
		frm(32'h1122_5566, 1'b1, 1'b0, 1'b0, 1'b1, 8'h01);
		frm(32'h1122_3345, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		rd(IDX_BG + 10'h003, 32'h0000_0045, RESP_OKAY);
		frm(32'h1122_7777, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
		rd(IDX_FG + 10'h002, 32'h0000_0077, RESP_OKAY);
		wr(IDX_MASK + 10'h003, 8'h01);
		frm(32'h1122_3345, 1'b1, 1'b0, 1'b0, 1'b1, 8'h00);
		$display("test two filters done");
		wr(IDX_MODEHIT, 8'h10);
		frm(32'h5566_0000, 1'b1, 1'b0, 1'b0, 1'b1, 8'h13);
		frm(32'h3344_0000, 1'b1, 1'b0, 1'b0, 1'b1, 8'h11);
		wr(IDX_MODEHIT, 8'h20);
		frm(32'h5500_0000, 1'b0, 1'b0, 1'b0, 1'b1, 8'h26);
		frm(32'h22FF_FFFF, 1'b1, 1'b0, 1'b0, 1'b1, 8'h21);
		$display("test four and eight filters done");
		frm(32'h5500_0000, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
		chk(ACK_ENABLE, 1'b0);
		frm(32'h5500_0000, 1'b0, 1'b1, 1'b1, 1'b1, 8'h26);
		wr(IDX_CTRL, 8'h02);
		chk(LOOPBACK, 1'b1);
		frm(32'h5500_0000, 1'b0, 1'b1, 1'b0, 1'b1, 8'h26);
		wr(IDX_CTRL, 8'h00);
		$display("test own frames done");
		wr(IDX_TCTRL, 8'h02);
		@(posedge CLOCK);
		TX_BUF_AVAIL <= 3'b101;
		TX_ERR_CNT   <= 8'hA5;
		repeat (2) @(negedge CLOCK);
		chk(TX_EMPTY_IRQ, 1'b0);
		@(posedge CLOCK);
		TX_BUF_AVAIL <= 3'b010;
		repeat (2) @(negedge CLOCK);
		chk(TX_EMPTY_IRQ, 1'b1);
		wr(IDX_CTRL, 8'h01);
		wr(IDX_TCTRL, 8'h07);
		rd(IDX_TCTRL, 32'h0000_0000, RESP_OKAY);
		chk(TX_EMPTY_IRQ, 1'b0);
		wr(IDX_TXERR, 8'h00);
		rd(IDX_TXERR, 32'h0000_00A5, RESP_OKAY);
		wr(IDX_CTRL, 8'h00);
		$display("test transmit side done");
		final_report;
	end
endmodule
